//--- hdl/gauge_alarm_and_load_model.sv
// threshold alarms, load-model selection and reserve handling with an ahb-lite register slave
//
// Overview of operation
// [RULE_01] set capacity warning when remaining charge drops below its level
// [RULE_02] clear capacity warning once remaining charge climbs above its level
// [RULE_03] low-charge pin follows the capacity warning flag, gated by its enable bit
// [RULE_04] low-charge pin shows the warning only while its enable bit is set
// [RULE_05] voltage below shutdown set level sets shutdown flag and pulses event pin
// [RULE_06] voltage above clear level clears a set shutdown flag and pulses event pin
// [RULE_07] voltage at or below zero-charge level forces reported percentage to zero
// [RULE_08] model family 0 (default) is constant current, 1 constant power
// [RULE_09] load model indicator always mirrors the model family setting
// [RULE_10] current codes: 0 last cycle, 1 (default) present cycle, 2 averaged
// [RULE_11] current codes: 3 filtered, 4 capacity over 5, 5 hypothetical, 6 user
// [RULE_12] power codes: 0 last cycle, 1 present cycle, 2 averaged current times voltage
// [RULE_13] power codes: 3 filtered times voltage, 4 energy/5, 5 hypothetical, 6 user
// [RULE_14] track average discharge over each cycle, keep previous cycle's value
// [RULE_15] hold reserve charge and energy below reported zero, no-load compensated
// [RULE_16] low-charge interrupt only when pin enable set; enable resets cleared
// [RULE_17] flags update once per measurement and drive pins from registers
// [RULE_18] filtered current is a first-order recursive low-pass at update rate
//
// Added by the designer: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none

module gauge_alarm_and_load_model (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic meas_valid,
    input wire gauge_pkg::meas_t meas,
    output logic low_charge_pin,
    output logic event_pin,
    output logic irq,
    output logic load_model_indicator,
    output logic signed [15:0] load_rate,
    output logic [7:0] reported_percent,
    output logic [15:0] reported_charge,
    output logic [15:0] reported_energy
);
    import gauge_pkg::*;

    function automatic logic signed [15:0] avg_of(input logic signed [31:0] sum,
                                                   input logic [15:0] cnt);
        logic signed [31:0] q;
        q = 32'sh0;
        if (cnt != 16'h0) begin
            q = sum / $signed({16'h0, cnt});
        end
        return q[15:0];
    endfunction

    function automatic logic signed [15:0] power_of(input logic signed [15:0] i,
                                                     input logic [15:0] v);
        logic signed [33:0] p;
        // widen both factors first, a 17-bit product would drop the upper bits
        p = (34'(i) * 34'($signed({1'b0, v}))) / UW_PER_10MW;
        return p[15:0];
    endfunction

    function automatic logic [15:0] sat_sub(input logic [15:0] a, input logic [15:0] b);
        return (a > b) ? a - b : 16'h0;
    endfunction

    // bus side state
    logic dphase;
    logic d_write;
    logic [7:0] d_addr;

    // software registers
    logic load_mode;
    logic pin_enable;
    load_sel_t load_sel;
    logic [15:0] capacity_warn_level;
    logic [15:0] shutdown_set_voltage;
    logic [15:0] shutdown_clear_voltage;
    logic [15:0] zero_voltage;
    logic signed [15:0] user_current_rate;
    logic signed [15:0] user_power_rate;
    logic [15:0] design_capacity;
    logic [15:0] design_energy;
    logic [15:0] reserve_charge;
    logic [15:0] reserve_energy;
    logic signed [15:0] hypothetical_rate;
    logic [2:0] irq_stat;
    logic [2:0] irq_mask;

    // gauge state
    status_t status;
    logic signed [31:0] sum_i;
    logic signed [31:0] sum_p;
    logic [15:0] sum_cnt;
    logic signed [15:0] last_avg_i;
    logic signed [15:0] last_avg_p;
    logic signed [15:0] filt_i;

    logic signed [15:0] next_load_rate;
    logic next_cap_warn;
    logic next_shutdown;
    logic [2:0] irq_event;
    logic signed [15:0] meas_power;
    logic meas_discharge;
    logic [31:0] read_word;

    wire logic take = hsel && htrans[1] && hready;
    wire logic wr_now = dphase && d_write;

    // ---------------- ahb-lite slave ----------------
    // one wait state per transfer, so a read that follows a write sees the new value
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dphase <= 1'b0;
            d_write <= 1'b0;
            d_addr <= 8'h0;
            hreadyout <= 1'b1;
        end else if (take) begin
            dphase <= 1'b1;
            d_write <= hwrite;
            d_addr <= {haddr[7:2], 2'b00};
            hreadyout <= 1'b0;
        end else begin
            dphase <= 1'b0;
            hreadyout <= 1'b1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hresp <= 1'b0;
        end else begin
            hresp <= 1'b0;
        end
    end

    always_comb begin
        read_word = 32'h0;
        case (d_addr)
            OFS_CTRL: read_word = {25'h0, load_sel, 2'h0, pin_enable, load_mode};
            OFS_CAP_LEVEL: read_word = {16'h0, capacity_warn_level};
            OFS_SHUTDOWN_V: read_word = {shutdown_clear_voltage, shutdown_set_voltage};
            OFS_ZERO_V: read_word = {16'h0, zero_voltage};
            OFS_USER_RATE: read_word = {user_power_rate, user_current_rate};
            OFS_DESIGN: read_word = {design_energy, design_capacity};
            OFS_RESERVE: read_word = {reserve_energy, reserve_charge};
            OFS_HYPO_RATE: read_word = {16'h0, hypothetical_rate};
            OFS_STATUS: read_word = {28'h0, status};
            OFS_IRQ_STAT: read_word = {29'h0, irq_stat};
            OFS_IRQ_MASK: read_word = {29'h0, irq_mask};
            OFS_LOAD_RATE: read_word = {16'h0, load_rate};
            OFS_LAST_RUN: read_word = {last_avg_p, last_avg_i};
            OFS_FILT: read_word = {16'h0, filt_i};
            default: read_word = 32'h0;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0;
        end else if (dphase && !d_write) begin
            hrdata <= read_word;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            load_mode <= LOAD_MODE_RESET;
            pin_enable <= PIN_EN_RESET;
            load_sel <= load_sel_t'(LOAD_SEL_RESET);
            capacity_warn_level <= LEVEL_RESET;
            shutdown_set_voltage <= LEVEL_RESET;
            shutdown_clear_voltage <= LEVEL_RESET;
            zero_voltage <= LEVEL_RESET;
            user_current_rate <= LEVEL_RESET;
            user_power_rate <= LEVEL_RESET;
            design_capacity <= LEVEL_RESET;
            design_energy <= LEVEL_RESET;
            reserve_charge <= LEVEL_RESET;
            reserve_energy <= LEVEL_RESET;
            hypothetical_rate <= LEVEL_RESET;
            irq_mask <= IRQ_MASK_RESET;
        end else if (wr_now) begin
            case (d_addr)
                OFS_CTRL: begin
                    load_mode <= hwdata[CTRL_LOAD_MODE]; // see [RULE_08]
                    pin_enable <= hwdata[CTRL_PIN_EN];
                    load_sel <= load_sel_t'(hwdata[CTRL_SEL_LO +: 3]);
                end
                OFS_CAP_LEVEL: capacity_warn_level <= hwdata[15:0];
                OFS_SHUTDOWN_V: begin
                    shutdown_set_voltage <= hwdata[15:0];
                    shutdown_clear_voltage <= hwdata[31:16];
                end
                OFS_ZERO_V: zero_voltage <= hwdata[15:0];
                OFS_USER_RATE: begin
                    user_current_rate <= hwdata[15:0];
                    user_power_rate <= hwdata[31:16];
                end
                OFS_DESIGN: begin
                    design_capacity <= hwdata[15:0];
                    design_energy <= hwdata[31:16];
                end
                OFS_RESERVE: begin
                    reserve_charge <= hwdata[15:0];
                    reserve_energy <= hwdata[31:16];
                end
                OFS_HYPO_RATE: hypothetical_rate <= hwdata[15:0];
                OFS_IRQ_MASK: irq_mask <= hwdata[2:0];
                default: ;
            endcase
        end
    end

    // ---------------- threshold alarms ----------------
    always_comb begin
        next_cap_warn = status.capacity_warn_flag;
        next_shutdown = status.shutdown_warn_flag;
        if (meas_valid) begin
            if (meas.remaining_charge < capacity_warn_level) begin
                next_cap_warn = 1'b1; // see [RULE_01]
            end else if (meas.remaining_charge > capacity_warn_level) begin
                next_cap_warn = 1'b0; // see [RULE_02]
            end
            if (meas.cell_voltage < shutdown_set_voltage) begin
                next_shutdown = 1'b1; // see [RULE_05]
            end else if (status.shutdown_warn_flag
                         && meas.cell_voltage > shutdown_clear_voltage) begin
                next_shutdown = 1'b0; // see [RULE_06]
            end
        end
    end

    assign meas_discharge = meas.averaged_current < 16'sh0;
    assign meas_power = power_of(meas.averaged_current, meas.cell_voltage);

    // flags move only on a measurement, pins are flops so they never glitch
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            status <= '0;
            event_pin <= 1'b0;
            low_charge_pin <= 1'b0;
            load_model_indicator <= LOAD_MODE_RESET;
        end else begin
            status.capacity_warn_flag <= next_cap_warn; // see [RULE_17]
            status.shutdown_warn_flag <= next_shutdown;
            status.load_model_indicator <= load_mode; // see [RULE_09]
            if (meas_valid) begin
                status.discharging <= meas_discharge;
            end
            event_pin <= next_shutdown != status.shutdown_warn_flag; // see [RULE_05] [RULE_06]
            low_charge_pin <= status.capacity_warn_flag && pin_enable; // see [RULE_03] [RULE_04]
            load_model_indicator <= load_mode; // see [RULE_09]
        end
    end

    // ---------------- interrupts ----------------
    assign irq_event[IRQ_CAP_SET] = next_cap_warn && !status.capacity_warn_flag
                                    && pin_enable; // see [RULE_16]
    assign irq_event[IRQ_SD_SET] = next_shutdown && !status.shutdown_warn_flag;
    assign irq_event[IRQ_SD_CLEAR] = !next_shutdown && status.shutdown_warn_flag;

    // a new event wins over a write-one-to-clear in the same cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_stat <= 3'h0;
        end else if (wr_now && d_addr == OFS_IRQ_STAT) begin
            irq_stat <= (irq_stat & ~hwdata[2:0]) | irq_event;
        end else begin
            irq_stat <= irq_stat | irq_event;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_stat & irq_mask);
        end
    end

    // ---------------- discharge cycle averages ----------------
    // the sum saturates nowhere: a cycle longer than 65535 measurements wraps the count
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sum_i <= 32'sh0;
            sum_p <= 32'sh0;
            sum_cnt <= 16'h0;
            last_avg_i <= 16'sh0;
            last_avg_p <= 16'sh0;
        end else if (meas_valid && meas_discharge) begin
            sum_i <= sum_i + 32'(meas.averaged_current); // see [RULE_14]
            sum_p <= sum_p + 32'(meas_power);
            sum_cnt <= sum_cnt + 16'h1;
        end else if (meas_valid && sum_cnt != 16'h0) begin
            last_avg_i <= avg_of(sum_i, sum_cnt); // see [RULE_14]
            last_avg_p <= avg_of(sum_p, sum_cnt);
            sum_i <= 32'sh0;
            sum_p <= 32'sh0;
            sum_cnt <= 16'h0;
        end
    end

    // tau over update period is 14, so a shift of four is the nearest power of two
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            filt_i <= 16'sh0;
        end else if (meas_valid) begin
            filt_i <= filt_i + 16'((meas.averaged_current - filt_i) >>> FILT_SHIFT); // see [RULE_18]
        end
    end

    // ---------------- load basis selection ----------------
    always_comb begin
        next_load_rate = 16'sh0;
        if (!load_mode) begin
            case (load_sel)
                SEL_LAST_RUN: next_load_rate = last_avg_i; // see [RULE_10]
                SEL_PRESENT_AVG: next_load_rate = avg_of(sum_i, sum_cnt);
                SEL_AVERAGED: next_load_rate = meas.averaged_current;
                SEL_FILTERED: next_load_rate = filt_i; // see [RULE_11]
                SEL_C_RATE: next_load_rate = -$signed(design_capacity / C_RATE_DIV);
                SEL_HYPO_RATE: next_load_rate = hypothetical_rate;
                SEL_USER_RATE: next_load_rate = user_current_rate;
                default: next_load_rate = 16'sh0;
            endcase
        end else begin
            case (load_sel)
                SEL_LAST_RUN: next_load_rate = last_avg_p; // see [RULE_12]
                SEL_PRESENT_AVG: next_load_rate = avg_of(sum_p, sum_cnt);
                SEL_AVERAGED: next_load_rate = meas_power;
                SEL_FILTERED: next_load_rate = power_of(filt_i, meas.cell_voltage); // see [RULE_13]
                SEL_C_RATE: next_load_rate = -$signed(design_energy / C_RATE_DIV);
                SEL_HYPO_RATE: next_load_rate = hypothetical_rate;
                SEL_USER_RATE: next_load_rate = user_power_rate;
                default: next_load_rate = 16'sh0;
            endcase
        end
    end

    // reserve is taken off without load scaling, so reported zero leaves it in the cell
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            load_rate <= 16'sh0;
            reported_percent <= 8'h0;
            reported_charge <= 16'h0;
            reported_energy <= 16'h0;
        end else if (meas_valid) begin
            load_rate <= next_load_rate; // see [RULE_08]
            reported_percent <= (meas.cell_voltage <= zero_voltage) ? 8'h0
                                : meas.charge_percent; // see [RULE_07]
            reported_charge <= sat_sub(meas.remaining_charge, reserve_charge); // see [RULE_15]
            reported_energy <= sat_sub(meas.available_energy, reserve_energy); // see [RULE_15]
        end
    end

    // ---------------- assertions ----------------
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    cap_warn_set_a: assert property (meas_valid && meas.remaining_charge < capacity_warn_level
        |=> status.capacity_warn_flag) else $error("capacity warning not set"); // see [RULE_01]
    cap_warn_clear_a: assert property (meas_valid && meas.remaining_charge > capacity_warn_level
        |=> !status.capacity_warn_flag ##1 !low_charge_pin)
        else $error("capacity warning or pin not cleared"); // see [RULE_02]
    low_pin_follow_a: assert property (##1 low_charge_pin
        == $past(status.capacity_warn_flag && pin_enable))
        else $error("low-charge pin does not follow flag"); // see [RULE_03]
    low_pin_gate_a: assert property (!pin_enable ##1 !pin_enable |-> !low_charge_pin)
        else $error("low-charge pin active while disabled"); // see [RULE_04]
    shutdown_set_a: assert property (meas_valid && meas.cell_voltage < shutdown_set_voltage
        && !status.shutdown_warn_flag |=> status.shutdown_warn_flag && event_pin)
        else $error("shutdown set without event"); // see [RULE_05]
    shutdown_clear_a: assert property (meas_valid && status.shutdown_warn_flag
        && meas.cell_voltage > shutdown_clear_voltage
        && meas.cell_voltage >= shutdown_set_voltage
        |=> !status.shutdown_warn_flag && event_pin)
        else $error("shutdown clear without event"); // see [RULE_06]
    event_quiet_a: assert property (!meas_valid |=> !event_pin)
        else $error("event pin without measurement"); // see [RULE_17]
    zero_percent_a: assert property (meas_valid && meas.cell_voltage <= zero_voltage
        |=> reported_percent == 8'h0) else $error("percentage not forced to zero"); // see [RULE_07]
    model_mirror_a: assert property (##1 status.load_model_indicator == $past(load_mode))
        else $error("load model indicator stale"); // see [RULE_09]
    user_rate_a: assert property (meas_valid && !load_mode && load_sel == SEL_USER_RATE
        |=> load_rate == $past(user_current_rate))
        else $error("user current rate not selected"); // see [RULE_11]
    reserve_hold_a: assert property (meas_valid && meas.remaining_charge <= reserve_charge
        |=> reported_charge == 16'h0) else $error("reserve not held back"); // see [RULE_15]
    low_irq_gate_a: assert property (!pin_enable && !irq_stat[IRQ_CAP_SET]
        |=> !irq_stat[IRQ_CAP_SET])
        else $error("low-charge interrupt while disabled"); // see [RULE_16]

    cap_warn_c: cover property (!status.capacity_warn_flag ##1 status.capacity_warn_flag);
    shutdown_cycle_c: cover property (status.shutdown_warn_flag ##1 !status.shutdown_warn_flag);
    irq_raise_c: cover property (!irq ##1 irq);
    cycle_end_c: cover property (meas_valid && !meas_discharge && sum_cnt != 16'h0);

endmodule

`default_nettype wire

//--- hdl/gauge_pkg.sv
// constants and carrier types for the gauge alarm and load model block
package gauge_pkg;

    // register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_CAP_LEVEL = 8'h04;
    localparam logic [7:0] OFS_SHUTDOWN_V = 8'h08;
    localparam logic [7:0] OFS_ZERO_V = 8'h0c;
    localparam logic [7:0] OFS_USER_RATE = 8'h10;
    localparam logic [7:0] OFS_DESIGN = 8'h14;
    localparam logic [7:0] OFS_RESERVE = 8'h18;
    localparam logic [7:0] OFS_HYPO_RATE = 8'h1c;
    localparam logic [7:0] OFS_STATUS = 8'h20;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h24;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h28;
    localparam logic [7:0] OFS_LOAD_RATE = 8'h2c;
    localparam logic [7:0] OFS_LAST_RUN = 8'h30;
    localparam logic [7:0] OFS_FILT = 8'h34;

    // control word fields
    localparam int CTRL_LOAD_MODE = 0;
    localparam int CTRL_PIN_EN = 1;
    localparam int CTRL_SEL_LO = 4;

    // reset values
    localparam logic LOAD_MODE_RESET = 1'b0;
    localparam logic PIN_EN_RESET = 1'b0;
    localparam logic [2:0] LOAD_SEL_RESET = 3'h1;
    localparam logic [15:0] LEVEL_RESET = 16'h0000;
    localparam logic [2:0] IRQ_MASK_RESET = 3'h0;

    // interrupt status bits
    localparam int IRQ_CAP_SET = 0;
    localparam int IRQ_SD_SET = 1;
    localparam int IRQ_SD_CLEAR = 2;

    // load-compensation arithmetic
    localparam int TAU_MS = 14000;
    localparam int MEAS_PERIOD_MS = 1000;
    localparam int FILT_SHIFT = $clog2(TAU_MS / MEAS_PERIOD_MS);
    localparam logic [15:0] C_RATE_DIV = 16'h0005;
    localparam logic signed [33:0] UW_PER_10MW = 34'sh0000_2710;

    typedef enum logic [2:0] {
        SEL_LAST_RUN = 3'h0,
        SEL_PRESENT_AVG = 3'h1,
        SEL_AVERAGED = 3'h2,
        SEL_FILTERED = 3'h3,
        SEL_C_RATE = 3'h4,
        SEL_HYPO_RATE = 3'h5,
        SEL_USER_RATE = 3'h6
    } load_sel_t;

    typedef struct packed {
        logic [15:0] remaining_charge;
        logic [15:0] available_energy;
        logic [15:0] cell_voltage;
        logic signed [15:0] averaged_current;
        logic [7:0] charge_percent;
    } meas_t;

    typedef struct packed {
        logic discharging;
        logic load_model_indicator;
        logic shutdown_warn_flag;
        logic capacity_warn_flag;
    } status_t;

endpackage

//--- sim/gauge_host_model.sv
// host side model that watches the gauge pins and counts event pulses
`timescale 1ns/1ps
`default_nettype none
module gauge_host_model (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic event_pin,
    input wire logic low_charge_pin,
    output int events,
    output logic low_seen
);
    // a pulse lasts one cycle, so sampling every edge counts each once
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            events <= 0;
            low_seen <= 1'b0;
        end else begin
            events <= events + int'(event_pin);
            low_seen <= low_seen | low_charge_pin;
        end
    end
endmodule
`default_nettype wire

//--- sim/gauge_alarm_and_load_model_bench.sv
// directed bench for the gauge alarm and load model block
`timescale 1ns/1ps
`default_nettype none
module gauge_alarm_and_load_model_bench;
    import gauge_pkg::*;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, meas_valid, irq, ev, lcp, lmi;
    logic [31:0] haddr, hwdata, hrdata, r;
    logic [1:0] htrans;
    logic [2:0] hsize;
    meas_t meas;
    logic signed [15:0] load_rate;
    logic [7:0] rpct;
    logic [15:0] rchg, reng;
    int mismatches, samples_checked, events, filt, fp, e;
    logic low_seen;
    gauge_alarm_and_load_model dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .meas_valid(meas_valid), .meas(meas), .low_charge_pin(lcp), .event_pin(ev),
        .irq(irq), .load_model_indicator(lmi), .load_rate(load_rate),
        .reported_percent(rpct), .reported_charge(rchg), .reported_energy(reng));
    gauge_host_model host (.hclk(hclk), .hresetn(hresetn), .event_pin(ev),
        .low_charge_pin(lcp), .events(events), .low_seen(low_seen));
    initial begin
        hclk = 1'b0;
        forever #2.5 hclk = ~hclk;
    end
    task automatic wrap_up;
        $display("checked %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // the master never assumes the one wait state, it polls under a bound
    task automatic wait_ready;
        int n;
        n = 0;
        @(posedge hclk);
        while (hreadyout !== 1'b1 && n < 40) begin
            @(posedge hclk);
            n++;
        end
        if (n >= 40) begin
            mismatches++;
            wrap_up();
        end
    endtask
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_ready();
        r = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        chk(r, exp);
        chk({31'h0, hresp}, 32'h0);
    endtask
    task automatic mi(input logic [15:0] rc, input logic [15:0] v,
            input logic signed [15:0] c, input logic [7:0] p);
        meas <= {rc, 16'h0190, v, c, p};
        meas_valid <= 1'b1;
        @(posedge hclk);
        meas_valid <= 1'b0;
        // the load basis is picked from the filter value held before this sample
        fp = filt;
        filt = filt + ((int'(c) - filt) >>> 4);
        repeat (3) @(posedge hclk);
    endtask
    initial begin
        {hresetn, hsel, hwrite, meas_valid, meas, haddr, hwdata, htrans} = '0;
        {mismatches, samples_checked, filt} = '0;
        hsize = 3'h2;
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd(OFS_CTRL, 32'h0000_0010);
        rd(8'h3c, 32'h0);
        rd(OFS_IRQ_MASK, 32'h0);
        $display("test reset done");
        wr(OFS_CAP_LEVEL, 32'd100);
        wr(OFS_IRQ_MASK, 32'h7);
        wr(OFS_CTRL, 32'h12);
        mi(16'd99, 16'd3700, 16'sd0, 8'd20);
        rd(OFS_STATUS, 32'h1);
        chk({31'h0, lcp}, 32'h1);
        chk({31'h0, irq}, 32'h1);
        mi(16'd100, 16'd3700, 16'sd0, 8'd20);
        rd(OFS_STATUS, 32'h1);
        mi(16'd101, 16'd3700, 16'sd0, 8'd20);
        rd(OFS_STATUS, 32'h0);
        chk({31'h0, lcp}, 32'h0);
        wr(OFS_IRQ_STAT, 32'h7);
        @(posedge hclk);
        chk({31'h0, irq}, 32'h0);
        wr(OFS_CTRL, 32'h10);
        mi(16'd50, 16'd3700, 16'sd0, 8'd20);
        chk({31'h0, lcp}, 32'h0);
        rd(OFS_IRQ_STAT, 32'h0);
        $display("test capacity done");
        wr(OFS_SHUTDOWN_V, {16'd3500, 16'd3000});
        mi(16'd500, 16'd2900, 16'sd0, 8'd5);
        rd(OFS_STATUS, 32'h2);
        chk(32'(events), 32'd1);
        mi(16'd500, 16'd3200, 16'sd0, 8'd5);
        chk(32'(events), 32'd1);
        mi(16'd500, 16'd3600, 16'sd0, 8'd5);
        rd(OFS_STATUS, 32'h0);
        chk(32'(events), 32'd2);
        wr(OFS_ZERO_V, 32'd2800);
        mi(16'd500, 16'd2800, 16'sd0, 8'd40);
        chk({24'h0, rpct}, 32'h0);
        mi(16'd500, 16'd3600, 16'sd0, 8'd40);
        chk({24'h0, rpct}, 32'd40);
        $display("test shutdown done");
        mi(16'd500, 16'd3600, -16'sd100, 8'd40);
        mi(16'd500, 16'd3600, -16'sd300, 8'd40);
        // the present average excludes the sample that arrives with it
        chk({16'h0, load_rate}, 32'h0000_ff9c);
        // a charging step closes the discharge cycle and logs its averages
        mi(16'd500, 16'd3600, 16'sd50, 8'd40);
        wr(OFS_USER_RATE, 32'hfea2_ff9c);
        wr(OFS_DESIGN, {16'd1000, 16'd2000});
        wr(OFS_HYPO_RATE, 32'd123);
        wr(OFS_RESERVE, {16'd30, 16'd100});
        // charging steps leave the logged discharge averages alone
        for (int m = 0; m < 2; m++) begin
            for (int s = 0; s < 7; s++) begin
                wr(OFS_CTRL, 32'(m) | 32'(s << 4));
                mi(16'd500, 16'd3600, 16'sd50, 8'd50);
                case (s)
                    0: e = m ? -72 : -200;
                    2: e = m ? 18 : 50;
                    3: e = m ? fp * 3600 / 10000 : fp;
                    4: e = m ? -200 : -400;
                    5: e = 123;
                    6: e = m ? -350 : -100;
                    default: e = 0;
                endcase
                chk({16'h0, load_rate}, {16'h0, e[15:0]});
                chk({31'h0, lmi}, 32'(m));
            end
        end
        chk({16'h0, rchg}, 32'd400);
        chk({16'h0, reng}, 32'd370);
        mi(16'd50, 16'd3600, 16'sd50, 8'd50);
        chk({16'h0, rchg}, 32'h0);
        $display("test load model done");
        wrap_up();
    end
endmodule
`default_nettype wire
